// ==== hdl/reset_source_controller.sv ====
`timescale 1ns/10ps
`default_nettype none

module reset_source_controller
    import rst_ctrl_pkg::*;
#(
    parameter logic [31:0] WDT_PERIOD_DEFAULT = WDT_PERIOD_RST
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire sup_pins_t   i_supply_pins,
    output logic             o_device_reset,
    output logic             o_initial_monitor_en,
    output logic             o_precise_dig_en,
    output logic             o_precise_ana_en,
    output logic             o_voltage_monitor_en,
    output logic      [3:0]  o_dig_trip_sel,
    output logic      [3:0]  o_ana_trip_sel,
    output logic             o_monitor_irq,
    output logic             o_wake_req,
    output logic             o_ext_pullup_en
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    sup_pins_t              pin_s1;
    sup_pins_t              pin_s2;
    sup_pins_t              pin_s3;
    sup_pins_t              pins;
    logic                   sys_rst;
    logic                   acc_wr;
    logic                   acc_rd;
    logic                   wr_ctrl;
    logic                   wr_status;
    logic                   wr_wdt;
    logic [31:0]            rd_mux;
    logic                   sw_block;
    logic                   ana_reg_en;
    logic                   dlv_rst_mode;
    logic                   alv_rst_mode;
    logic                   sw_req;
    logic [31:0]            wdt_period;
    logic [31:0]            wdt_cnt;
    logic                   wdt_en;
    logic                   wdt_hit;
    logic                   wdt_kick;
    logic [31:0]            buzz_period;
    logic [31:0]            buzz_cnt;
    logic                   buzz_on;
    logic                   boot_done;
    logic                   awake;
    logic                   prec_dig_live;
    logic                   prec_ana_live;
    logic                   mon_live;
    logic                   dlv_evt;
    logic                   alv_evt;
    logic                   ahv_evt;
    logic                   hold;
    cause_t                 causes_now;
    cause_t                 causes;
    logic                   reset_req;
    logic [POR_CNT_W-1:0]   rst_cnt;
    logic                   dlv_flag;
    logic                   alv_flag;
    logic                   ahv_flag;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_s1 <= PINS_RST;
            pin_s2 <= PINS_RST;
            pin_s3 <= PINS_RST;
        end else begin
            pin_s1 <= i_supply_pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Bit follows only when two stages agree
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pins <= PINS_RST;
        end else begin
            pins <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pins & (pin_s2 ^ pin_s3));
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave, one wait state
    // ------------------------------------------------------------------
    assign acc_wr    = i_avs_write && !o_avs_waitrequest;
    assign acc_rd    = i_avs_read && o_avs_waitrequest;
    assign wr_ctrl   = acc_wr && (i_avs_address == ADDR_CTRL);
    assign wr_status = acc_wr && (i_avs_address == ADDR_STATUS);
    assign wr_wdt    = acc_wr && (i_avs_address == ADDR_WDT_CTRL);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (i_avs_address)
            ADDR_CTRL: begin
                rd_mux[CTRL_SW_BLOCK]   = sw_block;
                rd_mux[CTRL_ANA_REG_EN] = ana_reg_en;
                rd_mux[CTRL_DLV_RESET]  = dlv_rst_mode;
                rd_mux[CTRL_ALV_RESET]  = alv_rst_mode;
            end
            ADDR_TRIP: begin
                rd_mux[TRIP_DIG_LSB +: 4] = o_dig_trip_sel;
                rd_mux[TRIP_ANA_LSB +: 4] = o_ana_trip_sel;
            end
            ADDR_STATUS: begin
                rd_mux[5:0]           = causes;
                rd_mux[STAT_DLV_FLAG] = dlv_flag;
                rd_mux[STAT_ALV_FLAG] = alv_flag;
                rd_mux[STAT_AHV_FLAG] = ahv_flag;
            end
            ADDR_WDT_CTRL: begin
                rd_mux[WDT_EN_BIT] = wdt_en;
            end
            ADDR_WDT_PERIOD: begin
                rd_mux = wdt_period;
            end
            ADDR_BUZZ_PERIOD: begin
                rd_mux = buzz_period;
            end
            ADDR_LEVEL: begin
                rd_mux = {trip_mv(o_ana_trip_sel), trip_mv(o_dig_trip_sel)};
            end
            ADDR_STATE: begin
                rd_mux[5:0] = {buzz_on, pins.hibernate, pins.sleep, wdt_en,
                               boot_done, mon_live};
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (acc_rd) begin
            o_avs_readdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Control registers, reset to defaults by every device reset
    // ------------------------------------------------------------------
    assign sys_rst = i_rst | o_device_reset;

    always_ff @(posedge i_core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sw_block     <= 1'b0;
            ana_reg_en   <= ANA_REG_EN_RST;
            dlv_rst_mode <= 1'b0;
            alv_rst_mode <= 1'b0;
        end else if (wr_ctrl) begin
            sw_block     <= i_avs_writedata[CTRL_SW_BLOCK];
            ana_reg_en   <= i_avs_writedata[CTRL_ANA_REG_EN];
            dlv_rst_mode <= i_avs_writedata[CTRL_DLV_RESET];
            alv_rst_mode <= i_avs_writedata[CTRL_ALV_RESET];
        end
    end

    // Trigger honoured only while block bit is clear
    always_ff @(posedge i_core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sw_req <= 1'b0;
        end else if (wr_ctrl && i_avs_writedata[CTRL_SW_TRIGGER] && !sw_block) begin
            sw_req <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            o_dig_trip_sel <= TRIP_SEL_RST;
            o_ana_trip_sel <= TRIP_SEL_RST;
        end else if (acc_wr && (i_avs_address == ADDR_TRIP)) begin
            o_dig_trip_sel <= i_avs_writedata[TRIP_DIG_LSB +: 4];
            o_ana_trip_sel <= i_avs_writedata[TRIP_ANA_LSB +: 4];
        end
    end

    always_ff @(posedge i_core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wdt_period  <= WDT_PERIOD_DEFAULT;
            buzz_period <= BUZZ_PERIOD_RST;
        end else if (acc_wr && (i_avs_address == ADDR_WDT_PERIOD)) begin
            wdt_period <= i_avs_writedata;
        end else if (acc_wr && (i_avs_address == ADDR_BUZZ_PERIOD)) begin
            buzz_period <= i_avs_writedata;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    assign wdt_kick = wr_wdt && i_avs_writedata[WDT_KICK_BIT];
    assign wdt_hit  = wdt_en && (wdt_cnt >= wdt_period);

    // Enable is set-only; only power-on clears it
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wdt_en <= 1'b0;
        end else if (wr_wdt && i_avs_writedata[WDT_EN_BIT]) begin
            wdt_en <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wdt_cnt <= 32'h0000_0000;
        end else if (!wdt_en || wdt_kick) begin
            wdt_cnt <= 32'h0000_0000;
        end else if (!wdt_hit) begin
            wdt_cnt <= wdt_cnt + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // Sleep buzzing
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            buzz_cnt <= 32'h0000_0000;
            buzz_on  <= 1'b0;
        end else if (!pins.sleep || pins.hibernate) begin
            buzz_cnt <= 32'h0000_0000;
            buzz_on  <= 1'b0;
        end else if (buzz_on && (buzz_cnt >= BUZZ_ON_CYC - 32'h0000_0001)) begin
            buzz_cnt <= 32'h0000_0000;
            buzz_on  <= 1'b0;
        end else if (!buzz_on && (buzz_cnt >= buzz_period)) begin
            buzz_cnt <= 32'h0000_0000;
            buzz_on  <= 1'b1;
        end else begin
            buzz_cnt <= buzz_cnt + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // Monitor gating and events
    // ------------------------------------------------------------------
    assign awake         = !pins.sleep && !pins.hibernate;
    assign prec_dig_live = boot_done && (awake || (buzz_on && !pins.hibernate));
    assign prec_ana_live = prec_dig_live && ana_reg_en;
    assign mon_live      = boot_done && (awake || (buzz_on && !pins.hibernate));
    assign dlv_evt       = mon_live && pins.dig_low;
    assign alv_evt       = mon_live && pins.ana_low;
    assign ahv_evt       = mon_live && pins.ana_high;
    assign hold          = !boot_done && pins.ramping;

    always_comb begin
        causes_now         = '0;
        causes_now.precise = (prec_dig_live && pins.prec_dig_trip) ||
                             (prec_ana_live && pins.prec_ana_trip);
        causes_now.ext     = !pins.ext_reset_n;
        causes_now.sw      = sw_req;
        causes_now.wdt     = wdt_hit;
        causes_now.dlv     = dlv_evt && dlv_rst_mode;
        causes_now.alv     = alv_evt && alv_rst_mode;
    end

    assign reset_req = |causes_now;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_initial_monitor_en <= 1'b1;
            o_precise_dig_en     <= 1'b0;
            o_precise_ana_en     <= 1'b0;
            o_voltage_monitor_en <= 1'b0;
            o_ext_pullup_en      <= 1'b1;
        end else begin
            o_initial_monitor_en <= !boot_done;
            o_precise_dig_en     <= prec_dig_live;
            o_precise_ana_en     <= prec_ana_live;
            o_voltage_monitor_en <= mon_live;
            o_ext_pullup_en      <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_device_reset <= 1'b1;
            rst_cnt        <= '0;
        end else if (reset_req || hold) begin
            o_device_reset <= 1'b1;
            rst_cnt        <= '0;
        end else if (rst_cnt < POR_MIN_CYC) begin
            rst_cnt <= rst_cnt + POR_CNT_W'(1);
        end else begin
            o_device_reset <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            boot_done <= 1'b0;
        end else if (!o_device_reset) begin
            boot_done <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Status: causes and monitor flags, power-on reset only
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            causes <= '0;
        end else if (reset_req && !o_device_reset) begin
            causes <= causes_now;
        end else if (o_device_reset) begin
            causes <= causes | causes_now;
        end
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            dlv_flag <= 1'b0;
            alv_flag <= 1'b0;
            ahv_flag <= 1'b0;
        end else begin
            dlv_flag <= (dlv_evt && !dlv_rst_mode) ||
                        (dlv_flag && !(wr_status && i_avs_writedata[STAT_DLV_FLAG]));
            alv_flag <= (alv_evt && !alv_rst_mode) ||
                        (alv_flag && !(wr_status && i_avs_writedata[STAT_ALV_FLAG]));
            ahv_flag <= ahv_evt ||
                        (ahv_flag && !(wr_status && i_avs_writedata[STAT_AHV_FLAG]));
        end
    end

    // Alert while asleep asks for wake; interrupt waits until awake
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wake_req    <= 1'b0;
            o_monitor_irq <= 1'b0;
        end else begin
            o_wake_req    <= pins.sleep && (o_wake_req || dlv_flag || alv_flag ||
                                            ahv_flag);
            o_monitor_irq <= awake && (dlv_flag || alv_flag || ahv_flag);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [7:0] hi_cnt;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            hi_cnt <= 8'h00;
        end else if (!o_device_reset) begin
            hi_cnt <= 8'h00;
        end else if (hi_cnt != 8'hff) begin
            hi_cnt <= hi_cnt + 8'h01;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    min_pulse_a: assert property ($fell(o_device_reset) |-> hi_cnt >= 8'(POR_MIN_CYC))
        else $error("device reset shorter than minimum");
    sw_reset_a: assert property (
        wr_ctrl && i_avs_writedata[CTRL_SW_TRIGGER] && !sw_block |-> ##2 o_device_reset)
        else $error("software reset did not assert device reset");
    sw_block_a: assert property (
        wr_ctrl && sw_block && !o_device_reset && !sw_req |=> !sw_req)
        else $error("blocked software reset was taken");
    wdt_sticky_a: assert property (wdt_en |=> wdt_en)
        else $error("watchdog enable cleared");
    wdt_fire_a: assert property (wdt_hit |-> ##1 o_device_reset)
        else $error("watchdog timeout gave no reset");
    ext_reset_a: assert property (!pins.ext_reset_n |=> o_device_reset [*2])
        else $error("external reset not held");
    mon_gate_a: assert property (!$past(boot_done) |-> !o_voltage_monitor_en)
        else $error("monitors on before power-on end");
    prec_hib_a: assert property ($past(pins.hibernate) |-> !o_precise_dig_en)
        else $error("precise monitor on in hibernate");
    irq_wake_a: assert property (o_monitor_irq |-> !$past(pins.sleep))
        else $error("interrupt raised while asleep");
    init_off_a: assert property ($past(boot_done) |-> !o_initial_monitor_en)
        else $error("initial monitor still on after boot");

endmodule
`default_nettype wire

// ==== pkg/rst_ctrl_pkg.sv ====
`default_nettype none
package rst_ctrl_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned POR_MIN_NS    = 150;
    localparam int unsigned POR_CNT_W     = 5;
    localparam logic [POR_CNT_W-1:0] POR_MIN_CYC =
        POR_CNT_W'((POR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [31:0] BUZZ_ON_CYC     = 32'h0000_0008;
    localparam logic [31:0] BUZZ_PERIOD_RST = 32'h0000_0400;
    localparam logic [31:0] WDT_PERIOD_RST  = 32'h000f_4240;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL        = 8'h00;
    localparam logic [7:0] ADDR_TRIP        = 8'h04;
    localparam logic [7:0] ADDR_STATUS      = 8'h08;
    localparam logic [7:0] ADDR_WDT_CTRL    = 8'h0c;
    localparam logic [7:0] ADDR_WDT_PERIOD  = 8'h10;
    localparam logic [7:0] ADDR_BUZZ_PERIOD = 8'h14;
    localparam logic [7:0] ADDR_LEVEL       = 8'h18;
    localparam logic [7:0] ADDR_STATE       = 8'h1c;

    localparam int unsigned CTRL_SW_TRIGGER = 0;
    localparam int unsigned CTRL_SW_BLOCK   = 1;
    localparam int unsigned CTRL_ANA_REG_EN = 2;
    localparam int unsigned CTRL_DLV_RESET  = 3;
    localparam int unsigned CTRL_ALV_RESET  = 4;
    localparam int unsigned TRIP_DIG_LSB    = 0;
    localparam int unsigned TRIP_ANA_LSB    = 4;
    localparam int unsigned STAT_DLV_FLAG   = 8;
    localparam int unsigned STAT_ALV_FLAG   = 9;
    localparam int unsigned STAT_AHV_FLAG   = 10;
    localparam int unsigned WDT_EN_BIT      = 0;
    localparam int unsigned WDT_KICK_BIT    = 1;

    localparam logic       ANA_REG_EN_RST = 1'b1;
    localparam logic [3:0] TRIP_SEL_RST   = 4'h0;

    // Trip level in millivolts: base plus code times step
    localparam logic [15:0] TRIP_BASE_MV = 16'd1700;
    localparam logic [15:0] TRIP_STEP_MV = 16'd250;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ext_reset_n;
        logic ramping;
        logic prec_dig_trip;
        logic prec_ana_trip;
        logic dig_low;
        logic ana_low;
        logic ana_high;
        logic sleep;
        logic hibernate;
    } sup_pins_t;

    localparam sup_pins_t PINS_RST = 9'h100;

    typedef struct packed {
        logic dlv;
        logic alv;
        logic wdt;
        logic sw;
        logic ext;
        logic precise;
    } cause_t;

    function automatic logic [15:0] trip_mv(input logic [3:0] code);
        logic [15:0] prod;
        prod = TRIP_STEP_MV * {12'h000, code};
        return TRIP_BASE_MV + prod;
    endfunction

endpackage
`default_nettype wire

// ==== testbench/ext_reset_driver.sv ====
`timescale 1ns/10ps
`default_nettype none
module ext_reset_driver import rst_ctrl_pkg::*; (
    input  wire logic      i_core_clk,
    input  wire logic      i_hold_low,
    input  wire sup_pins_t i_levels,
    output var sup_pins_t  o_pins
);
    int unsigned gap     = 0;
    logic        driving = 1'b0;

    always_ff @(posedge i_core_clk) begin
        if (driving && !i_hold_low) begin
            gap <= 1000;
        end else if (gap != 0) begin
            gap <= gap - 1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        driving <= i_hold_low && (driving || gap == 0);
    end

    // Released pin floats to the pull-up level
    always_comb begin
        o_pins = i_levels;
        o_pins.ext_reset_n = !driving;
    end
endmodule
`default_nettype wire

// ==== testbench/reset_source_controller_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module reset_source_controller_tb import rst_ctrl_pkg::*;;
    logic        clk, rst, rd, wr, hold, drst, initial_power_on_monitor, pdig, irq, pull, wreq, pana, vmon, wake;
    logic [7:0]  addr;
    logic [31:0] wdat, rdat, q;
    logic [3:0]  atrip, dtrip;
    sup_pins_t   lv, pins;
    int          mismatches, checked, n;

    reset_source_controller #(.WDT_PERIOD_DEFAULT(32'h0000_0040)) reset_source_controller_i (
        .i_core_clk(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .i_supply_pins(pins), .o_device_reset(drst),
        .o_initial_monitor_en(initial_power_on_monitor), .o_precise_dig_en(pdig), .o_precise_ana_en(pana),
        .o_voltage_monitor_en(vmon), .o_dig_trip_sel(dtrip), .o_ana_trip_sel(atrip),
        .o_monitor_irq(irq), .o_wake_req(wake), .o_ext_pullup_en(pull));

    ext_reset_driver ext_reset_driver_i (
        .i_core_clk(clk), .i_hold_low(hold), .i_levels(lv), .o_pins(pins));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        rd   <= !w;
        wr   <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            complete_run();
        end
    endtask

    task automatic wait_for(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk(32'(s), 32'(v));
        if (s !== v) complete_run();
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic por_check();
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (40) @(posedge clk);
        chk(32'(drst), 32'h1);
        chk(32'(vmon), 32'h0);
        lv.ramping <= 1'b0;
        wait_for(drst, 1'b0);
        repeat (2) @(posedge clk);
        chk(32'(initial_power_on_monitor), 32'h0);
        chk(32'(pdig), 32'h1);
        chk(32'(pana), 32'h1);
        chk(32'(vmon), 32'h1);
        chk(32'(pull), 32'h1);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, ADDR_STATE, 32'h0);
        chk(q & 32'h4, 32'h0);
    endtask

    task automatic monitor_check();
        bus(1'b1, ADDR_TRIP, 32'h0000_00f3);
        @(posedge clk);
        chk(32'(atrip), 32'hf);
        chk(32'(dtrip), 32'h3);
        bus(1'b0, ADDR_LEVEL, 32'h0);
        chk(q, {16'd5450, 16'd2450});
        bus(1'b1, ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(pana), 32'h0);
        chk(32'(pdig), 32'h1);
        bus(1'b1, ADDR_CTRL, 32'h4);
        lv.ana_high <= 1'b1;
        wait_for(irq, 1'b1);
        lv.ana_high <= 1'b0;
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q & 32'h400, 32'h400);
        repeat (8) @(posedge clk);
        bus(1'b1, ADDR_STATUS, 32'h400);
        wait_for(irq, 1'b0);
    endtask

    task automatic sleep_check();
        bus(1'b1, ADDR_BUZZ_PERIOD, 32'h20);
        lv.sleep    <= 1'b1;
        lv.ana_high <= 1'b1;
        repeat (10) @(posedge clk);
        chk(32'(pdig), 32'h0);
        chk(32'(irq), 32'h0);
        wait_for(pdig, 1'b1);
        wait_for(wake, 1'b1);
        chk(32'(irq), 32'h0);
        lv.sleep    <= 1'b0;
        lv.ana_high <= 1'b0;
        wait_for(irq, 1'b1);
        wait_for(wake, 1'b0);
        bus(1'b1, ADDR_STATUS, 32'h400);
        wait_for(irq, 1'b0);
        lv.sleep     <= 1'b1;
        lv.hibernate <= 1'b1;
        repeat (60) @(posedge clk);
        chk(32'(pdig), 32'h0);
        lv.sleep     <= 1'b0;
        lv.hibernate <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    task automatic ext_check();
        hold <= 1'b1;
        repeat (20) @(posedge clk);
        chk(32'(drst), 32'h1);
        hold <= 1'b0;
        wait_for(drst, 1'b0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q, 32'h2);
    endtask

    task automatic sw_check();
        bus(1'b1, ADDR_CTRL, 32'h6);
        bus(1'b1, ADDR_CTRL, 32'h7);
        repeat (10) @(posedge clk);
        chk(32'(drst), 32'h0);
        bus(1'b1, ADDR_CTRL, 32'h4);
        bus(1'b1, ADDR_CTRL, 32'h5);
        wait_for(drst, 1'b1);
        wait_for(drst, 1'b0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q, 32'h4);
    endtask

    task automatic mon_reset_check();
        lv.prec_dig_trip <= 1'b1;
        wait_for(drst, 1'b1);
        lv.prec_dig_trip <= 1'b0;
        wait_for(drst, 1'b0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q, 32'h1);
        bus(1'b1, ADDR_CTRL, 32'hc);
        lv.dig_low <= 1'b1;
        wait_for(drst, 1'b1);
        lv.dig_low <= 1'b0;
        wait_for(drst, 1'b0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q & 32'h3f, 32'h20);
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk(q, 32'h4);
        bus(1'b1, ADDR_STATUS, 32'h700);
    endtask

    task automatic wdt_check();
        bus(1'b1, ADDR_WDT_CTRL, 32'h1);
        bus(1'b1, ADDR_WDT_CTRL, 32'h0);
        bus(1'b0, ADDR_STATE, 32'h0);
        chk(q & 32'h4, 32'h4);
        repeat (3) begin
            repeat (40) @(posedge clk);
            bus(1'b1, ADDR_WDT_CTRL, 32'h3);
        end
        chk(32'(drst), 32'h0);
        wait_for(drst, 1'b1);
        wait_for(drst, 1'b0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q, 32'h8);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wait_for(drst, 1'b0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, ADDR_STATE, 32'h0);
        chk(q & 32'h4, 32'h0);
    endtask

    initial begin
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        hold = 1'b0;
        addr = 8'h00;
        wdat = 32'h0;
        lv = PINS_RST;
        lv.ramping = 1'b1;
        mismatches = 0;
        checked = 0;
        por_check();
        monitor_check();
        sleep_check();
        ext_check();
        sw_check();
        mon_reset_check();
        wdt_check();
        complete_run();
    end
endmodule
`default_nettype wire
